// File: shared/asram_pkg.sv
`default_nettype none
package asram_pkg;
  localparam int unsigned CLK_PERIOD_NS = 5;
  localparam int unsigned ADDR_W        = 21;
  localparam int unsigned DATA_W        = 16;
  localparam int unsigned BYTE_W        = 8;
  // device timing figures, in ns
  localparam int unsigned T_RC_NS  = 70;
  localparam int unsigned T_AA_NS  = 70;
  localparam int unsigned T_DOE_NS = 35;
  localparam int unsigned T_HZ_NS  = 25;
  localparam int unsigned T_WC_NS  = 70;
  localparam int unsigned T_AW_NS  = 60;
  localparam int unsigned T_SD_NS  = 30;
  localparam int unsigned T_HD_NS  = 0;
  localparam int unsigned T_HA_NS  = 0;
  localparam int unsigned T_SA_NS  = 0;
  localparam int unsigned T_BW_NS  = 60;
  // least times round up to whole cycles
  localparam int unsigned RD_CYC   = (T_AA_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned WR_CYC   = (T_AW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned HZ_CYC   = (T_HZ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CNT_W    = 5;
  localparam logic [CNT_W-1:0] RD_CNT = CNT_W'(RD_CYC);
  localparam logic [CNT_W-1:0] WR_CNT = CNT_W'(WR_CYC);
  localparam logic [CNT_W-1:0] HZ_CNT = CNT_W'(HZ_CYC);
  localparam logic [CNT_W-1:0] CNT_ONE = 5'h01;
  localparam logic [CNT_W-1:0] CNT_ZERO = 5'h00;
  typedef enum logic [2:0] {
    ASRAM_IDLE  = 3'b000,
    ASRAM_READ  = 3'b001,
    ASRAM_RDONE = 3'b011,
    ASRAM_WRITE = 3'b100,
    ASRAM_WEND  = 3'b110,
    ASRAM_TURN  = 3'b010
  } asram_state_e;
endpackage
`default_nettype wire

// File: core/asram_reset_sync.sv
`timescale 1ns/1ps
`default_nettype none
module asram_reset_sync (
  input  wire logic clk_i,
  input  wire logic reset_n_i,
  output logic      reset_n_o
);
  logic meta_r;
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      meta_r    <= 1'b0;
      reset_n_o <= 1'b0;
    end else begin
      meta_r    <= 1'b1;
      reset_n_o <= meta_r;
    end
  end
endmodule // asram_reset_sync
`default_nettype wire

// File: core/asram_host.sv
// How it works
// [RQ1] write happens only while write enable, both selects and a lane overlap
// [RQ2] device ends write when any qualifier drops; we drop all together
// [RQ3] write data stands 30 ns before write end, held past it
// [RQ4] address stands 60 ns before write end and through the ending edge
// [RQ5] qualifiers rise no earlier than the address is valid
// [RQ6] lanes and chip selects stay asserted 60 ns before write end
// [RQ7] read data valid 70 ns after address stable; sampled after that
// [RQ8] old data held 10 ns after address change; not relied on
// [RQ9] read data valid 35 ns after output enable asserts
// [RQ10] lane data valid 70 ns after lane enable asserts
// [RQ11] both lanes high means deselected
// [RQ12] deselected device floats data pins and stands by
// [RQ13] data pins float during write while output enable is high
// [RQ14] host never drives data while output enable is low
// [RQ15] dropping both selects with write enable high leaves pins floating
// [RQ16] device turn-off is faster than turn-on, so no contention
// [RQ17] low lane writes bits 7..0, high lane bits 15..8
// [RQ18] read needs selects, output enable low, write enable high
// [RQ19] array is 2M words of 16 bits, 21-bit word address
`timescale 1ns/1ps
`default_nettype none
module asram_host
  import asram_pkg::*;
(
  input  wire logic              mclk_i,
  input  wire logic              reset_n_i,
  input  wire logic              req_valid_i,
  input  wire logic              req_write_i,
  input  wire logic [ADDR_W-1:0] req_addr_i,
  input  wire logic [DATA_W-1:0] req_wdata_i,
  input  wire logic [1:0]        req_lane_i,
  output logic                   req_ready_o,
  output logic                   rsp_valid_o,
  output logic [DATA_W-1:0]      rsp_rdata_o,
  output logic [ADDR_W-1:0]      word_address_pins_o,
  output logic                   chip_select_low_active_n_o,
  output logic                   chip_select_high_active_o,
  output logic                   write_enable_n_o,
  output logic                   output_enable_n_o,
  output logic                   upper_byte_lane_n_o,
  output logic                   lower_byte_lane_n_o,
  output logic [DATA_W-1:0]      data_pins_o,
  output logic                   data_pins_oe_n_o,
  input  wire logic [DATA_W-1:0] data_pins_i
);
  logic             rst_n;
  asram_state_e     state_r;
  logic [CNT_W-1:0] cnt_r;
  logic [1:0]       lane_r;
  logic             take;

  asram_reset_sync u_rst (
    .clk_i     (mclk_i),
    .reset_n_i (reset_n_i),
    .reset_n_o (rst_n)
  );

  // an all-zero lane mask would deselect the device, so it is refused
  assign take = req_valid_i && req_ready_o && (req_lane_i != 2'b00); // see [RQ11]

  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ASRAM_IDLE;
      cnt_r   <= CNT_ZERO;
    end else begin
      case (state_r)
        ASRAM_IDLE: begin
          if (take) begin
            state_r <= req_write_i ? ASRAM_WRITE : ASRAM_READ;
            cnt_r   <= req_write_i ? WR_CNT : RD_CNT;
          end
        end
        ASRAM_READ: begin
          cnt_r <= cnt_r - CNT_ONE;
          if (cnt_r == CNT_ONE) begin
            state_r <= ASRAM_RDONE; // see [RQ7] [RQ9] [RQ10]
          end
        end
        ASRAM_RDONE: begin
          state_r <= ASRAM_TURN;
          cnt_r   <= HZ_CNT;
        end
        ASRAM_WRITE: begin
          cnt_r <= cnt_r - CNT_ONE;
          if (cnt_r == CNT_ONE) begin
            state_r <= ASRAM_WEND; // see [RQ4] [RQ6]
          end
        end
        ASRAM_WEND: begin
          state_r <= ASRAM_TURN;
          cnt_r   <= HZ_CNT;
        end
        ASRAM_TURN: begin
          // let a read driver float before the next cycle
          cnt_r <= cnt_r - CNT_ONE;
          if (cnt_r == CNT_ONE) begin
            state_r <= ASRAM_IDLE; // see [RQ16]
          end
        end
        default: begin
          state_r <= ASRAM_IDLE;
          cnt_r   <= CNT_ZERO;
        end
      endcase
    end
  end

  // address and lanes latched on take, held through the end edge
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      word_address_pins_o <= '0;
      lane_r              <= 2'b00;
      data_pins_o         <= '0;
    end else if (take) begin
      word_address_pins_o <= req_addr_i; // see [RQ4] [RQ19]
      lane_r              <= req_lane_i;
      data_pins_o         <= req_wdata_i; // see [RQ3] [RQ17]
    end
  end

  // qualifiers go active one cycle after the address, all drop together
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      chip_select_low_active_n_o <= 1'b1;
      chip_select_high_active_o  <= 1'b0;
      write_enable_n_o           <= 1'b1;
      output_enable_n_o          <= 1'b1;
      upper_byte_lane_n_o        <= 1'b1;
      lower_byte_lane_n_o        <= 1'b1;
      data_pins_oe_n_o           <= 1'b1;
    end else begin
      chip_select_low_active_n_o <= 1'b1;
      chip_select_high_active_o  <= 1'b0;
      write_enable_n_o           <= 1'b1; // see [RQ15]
      output_enable_n_o          <= 1'b1;
      upper_byte_lane_n_o        <= 1'b1;
      lower_byte_lane_n_o        <= 1'b1;
      data_pins_oe_n_o           <= 1'b1;
      // held through the last count, so the sample edge is a full 70 ns after the lanes
      if (state_r == ASRAM_READ) begin
        chip_select_low_active_n_o <= 1'b0; // see [RQ18]
        chip_select_high_active_o  <= 1'b1;
        output_enable_n_o          <= 1'b0;
        upper_byte_lane_n_o        <= ~lane_r[1];
        lower_byte_lane_n_o        <= ~lane_r[0];
      end
      if (state_r == ASRAM_WRITE) begin
        // output enable stays high so the device never drives here
        chip_select_low_active_n_o <= 1'b0; // see [RQ1] [RQ5] [RQ6]
        chip_select_high_active_o  <= 1'b1;
        write_enable_n_o           <= 1'b0;
        upper_byte_lane_n_o        <= ~lane_r[1];
        lower_byte_lane_n_o        <= ~lane_r[0];
        data_pins_oe_n_o           <= 1'b0; // see [RQ13] [RQ14]
      end
      // data still driven for one cycle past the write end
      if (state_r == ASRAM_WEND) begin
        data_pins_oe_n_o <= 1'b0; // see [RQ2] [RQ3]
      end
    end
  end

  // read data sampled at the last cycle of the held access
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      rsp_valid_o <= 1'b0;
      rsp_rdata_o <= '0;
      req_ready_o <= 1'b0;
    end else begin
      rsp_valid_o <= (state_r == ASRAM_RDONE);
      if (state_r == ASRAM_RDONE) begin
        rsp_rdata_o <= data_pins_i; // see [RQ7] [RQ18]
      end
      req_ready_o <= (state_r == ASRAM_IDLE) && !take
                  || (state_r == ASRAM_TURN) && (cnt_r == CNT_ONE);
    end
  end

  logic wr_win;
  assign wr_win = !write_enable_n_o && !chip_select_low_active_n_o
               && chip_select_high_active_o
               && !(upper_byte_lane_n_o && lower_byte_lane_n_o);

  sequence s_win_open;
    !wr_win ##1 wr_win;
  endsequence

  a_write_window_len: assert property (@(posedge mclk_i) disable iff (!rst_n) // see [RQ6]
    s_win_open |-> wr_win [*8] ##1 wr_win [*4])
    else $error("write window shorter than 60 ns");
  a_data_drive_win: assert property (@(posedge mclk_i) disable iff (!rst_n) // see [RQ3]
    wr_win |-> !data_pins_oe_n_o ##1 !data_pins_oe_n_o)
    else $error("write data not held around write end");
  a_addr_stable_w: assert property (@(posedge mclk_i) disable iff (!rst_n) // see [RQ4]
    wr_win |=> $stable(word_address_pins_o))
    else $error("address moved inside write");
  a_no_contention: assert property (@(posedge mclk_i) disable iff (!rst_n) // see [RQ14]
    !output_enable_n_o |-> data_pins_oe_n_o)
    else $error("host drives while output enabled");
  a_qual_after_addr: assert property (@(posedge mclk_i) disable iff (!rst_n) // see [RQ5]
    s_win_open |-> $stable(word_address_pins_o))
    else $error("write began with address change");
  a_read_hold_time: assert property (@(posedge mclk_i) disable iff (!rst_n) // see [RQ7]
    $fell(output_enable_n_o) |-> (!output_enable_n_o && write_enable_n_o) [*8]
      ##1 (!output_enable_n_o && write_enable_n_o) [*6] ##1 rsp_valid_o)
    else $error("read sampled before 70 ns");
  a_read_we_high: assert property (@(posedge mclk_i) disable iff (!rst_n) // see [RQ18]
    !output_enable_n_o |-> write_enable_n_o && !chip_select_low_active_n_o)
    else $error("read without proper selects");
  a_lane_not_idle: assert property (@(posedge mclk_i) disable iff (!rst_n) // see [RQ11]
    !chip_select_low_active_n_o |-> !(upper_byte_lane_n_o && lower_byte_lane_n_o))
    else $error("selected with no lane");
endmodule // asram_host
`default_nettype wire

// File: test/asram_dev_model.sv
`timescale 1ns/1ps
`default_nettype none
module asram_dev_model
  import asram_pkg::*;
(
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic              cs_n_i,
  input  wire logic              cs_i,
  input  wire logic              we_n_i,
  input  wire logic              oe_n_i,
  input  wire logic              ub_n_i,
  input  wire logic              lb_n_i,
  input  wire logic [DATA_W-1:0] host_d_i,
  input  wire logic              host_oe_n_i,
  input  wire logic              slow_i,
  output logic [DATA_W-1:0]      bus_o,
  output logic                   err_o
);
  logic [DATA_W-1:0] mem [logic [ADDR_W-1:0]];
  logic [DATA_W-1:0] fl_r = 16'h5a5a;
  logic [1:0]        ln_r;
  logic              armed = 1'b0;
  realtime           t_a, t_c, t_d, t_w;
  wire logic sel = !cs_n_i && cs_i && !(ub_n_i && lb_n_i);
  wire logic wr  = sel && !we_n_i;
  wire logic rd  = sel && we_n_i && !oe_n_i;
  initial err_o = 1'b0;
  always @(addr_i) t_a = $realtime;
  always @(cs_n_i, cs_i, oe_n_i, ub_n_i, lb_n_i) t_c = $realtime;
  always @(host_d_i, host_oe_n_i) t_d = $realtime;
  always @(posedge wr) begin
    t_w = $realtime;
    ln_r = {!ub_n_i, !lb_n_i};
    armed = 1'b1;
  end
  // any qualifier dropping ends the write; the settle from unknown at start is none
  always @(negedge wr) begin
    if (armed) begin
      if ($realtime - t_a < T_AW_NS || $realtime - t_d < T_SD_NS)
        err_o = 1'b1;
      if ($realtime - t_w < T_BW_NS || host_oe_n_i) err_o = 1'b1;
      if (ln_r[0]) mem[addr_i][7:0] = host_d_i[7:0];
      if (ln_r[1]) mem[addr_i][15:8] = host_d_i[15:8];
    end
    armed = 1'b0;
  end
  // slow mode answers just inside the access time; released lanes toggle
  always #1 begin
    if (rd && $realtime - t_a >= (slow_i ? 69 : 5) && $realtime - t_c >= (slow_i ? 69 : 5))
      fl_r = {ub_n_i ? ~fl_r[15:8] : mem[addr_i][15:8],
              lb_n_i ? ~fl_r[7:0] : mem[addr_i][7:0]};
    else if (!rd || $realtime - t_a >= 10)
      fl_r = ~fl_r;
    if (rd && !host_oe_n_i) err_o = 1'b1;
  end
  assign bus_o = host_oe_n_i ? fl_r : host_d_i;
endmodule // asram_dev_model
`default_nettype wire

// File: test/async_sram_byte_lane_access_test.sv
`timescale 1ns/1ps
`default_nettype none
module async_sram_byte_lane_access_test;
  import asram_pkg::*;
  logic              mclk_i = 1'b0;
  logic              reset_n_i = 1'b0;
  logic              req_valid_i = 1'b0;
  logic              req_write_i = 1'b0;
  logic [ADDR_W-1:0] req_addr_i = '0;
  logic [DATA_W-1:0] req_wdata_i = '0;
  logic [1:0]        req_lane_i = 2'h0;
  logic              slow = 1'b0;
  logic              rdy, rsp, cs_n, cs, we_n, oe_n, ub_n, lb_n, d_oe_n, err;
  logic [DATA_W-1:0] rdata, d_o, d_i;
  logic [ADDR_W-1:0] a_o;
  int                n_fail = 0;
  int                checks_done = 0;
  always #(CLK_PERIOD_NS / 2.0) mclk_i = ~mclk_i;
  asram_host asram_host_inst (.mclk_i(mclk_i), .reset_n_i(reset_n_i),
    .req_valid_i(req_valid_i), .req_write_i(req_write_i), .req_addr_i(req_addr_i),
    .req_wdata_i(req_wdata_i), .req_lane_i(req_lane_i), .req_ready_o(rdy),
    .rsp_valid_o(rsp), .rsp_rdata_o(rdata), .word_address_pins_o(a_o),
    .chip_select_low_active_n_o(cs_n), .chip_select_high_active_o(cs),
    .write_enable_n_o(we_n), .output_enable_n_o(oe_n), .upper_byte_lane_n_o(ub_n),
    .lower_byte_lane_n_o(lb_n), .data_pins_o(d_o), .data_pins_oe_n_o(d_oe_n),
    .data_pins_i(d_i));
  asram_dev_model asram_dev_model_inst (.addr_i(a_o), .cs_n_i(cs_n), .cs_i(cs),
    .we_n_i(we_n), .oe_n_i(oe_n), .ub_n_i(ub_n), .lb_n_i(lb_n), .host_d_i(d_o),
    .host_oe_n_i(d_oe_n), .slow_i(slow), .bus_o(d_i), .err_o(err));
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic check(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // holds the request until an edge sees ready high
  task automatic issue(input logic wr, input logic [ADDR_W-1:0] a,
                       input logic [DATA_W-1:0] d, input logic [1:0] ln);
    int i;
    // one edge apart from whatever the previous call lowered
    @(posedge mclk_i);
    req_valid_i <= 1'b1;
    req_write_i <= wr;
    req_addr_i <= a;
    req_wdata_i <= d;
    req_lane_i <= ln;
    i = 0;
    do begin
      @(posedge mclk_i);
      i++;
    end while (rdy !== 1'b1 && i < 60);
    req_valid_i <= 1'b0;
    check({15'h0000, rdy}, 16'h0001);
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
    int i;
    issue(1'b0, a, 16'h0000, 2'h3);
    i = 0;
    do begin
      @(posedge mclk_i);
      i++;
    end while (rsp !== 1'b1 && i < 40);
    // strobes rise one edge after take, sampled a full access later, seen one edge on
    check(16'(i), 16'(RD_CYC + 2));
    check(rdata, exp);
  endtask
  task automatic t_reset();
    check({8'h00, cs_n, cs, we_n, oe_n, ub_n, lb_n, d_oe_n, rdy}, 16'h00be);
  endtask
  task automatic t_word();
    issue(1'b1, 21'h1f_ffff, 16'ha5c3, 2'h3);
    rd(21'h1f_ffff, 16'ha5c3);
  endtask
  task automatic t_lanes();
    issue(1'b1, 21'h00_0000, 16'h1111, 2'h3);
    issue(1'b1, 21'h00_0000, 16'habcd, 2'h2);
    issue(1'b1, 21'h00_0000, 16'h22ef, 2'h1);
    rd(21'h00_0000, 16'habef);
  endtask
  // lane 00 must be dropped without a sign
  task automatic t_refuse();
    issue(1'b0, 21'h00_0000, 16'h0000, 2'h0);
    @(posedge mclk_i);
    req_valid_i <= 1'b1;
    repeat (4) @(posedge mclk_i);
    check({13'h0000, cs_n, rsp, rdy}, 16'h0005);
    req_valid_i <= 1'b0;
    rd(21'h00_0000, 16'habef);
  endtask
  task automatic t_slow();
    slow <= 1'b1;
    issue(1'b1, 21'h0a_5a5a, 16'h5e71, 2'h3);
    rd(21'h0a_5a5a, 16'h5e71);
    slow <= 1'b0;
  endtask
  initial begin
    #20000;
    n_fail++;
    print_verdict();
  end
  initial begin
    repeat (8) @(posedge mclk_i);
    t_reset();
    reset_n_i <= 1'b1;
    repeat (4) @(posedge mclk_i);
    t_word();
    t_lanes();
    t_refuse();
    t_slow();
    check({15'h0000, err}, 16'h0000);
    print_verdict();
  end
endmodule // async_sram_byte_lane_access_test
`default_nettype wire
